/* File: flash_seq_pkg.sv */
`default_nettype none
package flash_seq_pkg;

  // Device register index on the 16-bit register bus (plain defaults)
  localparam logic [7:0] REG_OP_CONTROL_LOW = 8'h00;
  localparam logic [7:0] REG_OP_CONTROL_HIGH = 8'h01;
  localparam logic [7:0] REG_SECTOR_MASK_LOW = 8'h02;
  localparam logic [7:0] REG_SECTOR_MASK_HIGH = 8'h03;
  localparam logic [7:0] REG_TARGET_ADDR_LOW = 8'h04;
  localparam logic [7:0] REG_TARGET_ADDR_HIGH = 8'h05;
  localparam logic [7:0] REG_DATA0_LOW = 8'h06;
  localparam logic [7:0] REG_DATA0_HIGH = 8'h07;
  localparam logic [7:0] REG_DATA1_LOW = 8'h08;
  localparam logic [7:0] REG_DATA1_HIGH = 8'h09;
  localparam logic [7:0] REG_OP_ERROR = 8'h0a;

  // Operation control high fields, plus the control low lock bit and target address bit 2
  localparam logic [15:0] WORD_PROG_SEL = 16'h2000;
  localparam logic [15:0] DWORD_PROG_SEL = 16'h1000;
  localparam logic [15:0] ERASE_SEL = 16'h0800;
  localparam logic [15:0] SET_PROTECT_SEL = 16'h0100;
  localparam logic [15:0] PAUSE_REQUEST = 16'h4000;
  localparam logic [15:0] OP_START_BIT = 16'h8000;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam int LOCK_BIT = 4;
  localparam int ADDR_BIT2 = 2;

  // Non-volatile guard registers and their data words
  localparam logic [15:0] NV_ACCESS_GUARD_REG0_LOW = 16'hdfb8;
  localparam logic [15:0] NV_GUARD_DISABLE_REG_LOW = 16'hdfbc;
  localparam logic [15:0] NV_GUARD_ADDR_HIGH = 16'h000e;
  localparam logic [15:0] GUARD_ON_DATA = 16'hfffc;
  localparam logic [15:0] CLEAR_BIT0_DATA = 16'hfffe;
  localparam logic [4:0] GUARD_SLOTS = 5'h10;

  // Host register offsets
  localparam logic [3:0] H_CMD = 4'h0;
  localparam logic [3:0] H_ADDR_LO = 4'h1;
  localparam logic [3:0] H_ADDR_HI = 4'h2;
  localparam logic [3:0] H_D0L = 4'h3;
  localparam logic [3:0] H_D0H = 4'h4;
  localparam logic [3:0] H_D1L = 4'h5;
  localparam logic [3:0] H_D1H = 4'h6;
  localparam logic [3:0] H_MASK_LO = 4'h7;
  localparam logic [3:0] H_MASK_HI = 4'h8;
  localparam logic [3:0] H_STATUS = 4'h9;
  localparam logic [3:0] H_ERR = 4'ha;
  localparam logic [3:0] H_RMASK_LO = 4'hb;
  localparam logic [3:0] H_RMASK_HI = 4'hc;

  // Command word fields
  localparam int CMD_ARM_BIT = 4;
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_WORD = 4'h1;
  localparam logic [3:0] OP_DWORD = 4'h2;
  localparam logic [3:0] OP_ERASE = 4'h3;
  localparam logic [3:0] OP_PROT = 4'h4;
  localparam logic [3:0] OP_GUARD_ON = 4'h5;
  localparam logic [3:0] OP_GUARD_OFF = 4'h6;
  localparam logic [3:0] OP_GUARD_BACK = 4'h7;
  localparam logic [3:0] OP_SUSPEND = 4'h8;
  localparam logic [3:0] OP_RESUME = 4'h9;
  localparam logic [3:0] OP_CANCEL = 4'ha;
  localparam logic [3:0] OP_GO = 4'hb;

  // Status register bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_ARMED = 3;
  localparam int ST_SUSPENDED = 4;
  localparam int ST_GUARDED = 5;
  localparam int ST_ERROR = 6;
  localparam int ST_SLOTS_LSB = 8;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } bus_req_s;

endpackage
`default_nettype wire

/* File: reg_bus_port.sv */
`default_nettype none
module reg_bus_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Request from the sequencer
  input wire logic req_valid,
  input wire flash_seq_pkg::bus_req_s req,
  output logic done,
  output logic [15:0] rdata,
  // Device register bus
  output logic [7:0] dev_addr,
  output logic [15:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [15:0] dev_rdata
);

  logic cap_r;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      dev_wr <= 1'b0;
      dev_rd <= 1'b0;
      dev_addr <= 8'h00;
      dev_wdata <= 16'h0000;
      cap_r <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
    end
    else
    begin
      // Every access is one 16-bit word
      dev_wr <= req_valid & req.wr;
      dev_rd <= req_valid & req.rd;
      if (req_valid)
      begin
        dev_addr <= req.addr;
        dev_wdata <= req.wdata;
      end
      // Read data stand one cycle after the read strobe
      cap_r <= dev_rd;
      done <= dev_wr | cap_r;
      if (cap_r)
        rdata <= dev_rdata;
    end
  end

endmodule
`default_nettype wire

/* File: flash_write_op_sequencer.sv */
// Our own choices: the register offsets and the strobed register port.
`default_nettype none
module flash_write_op_sequencer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host register port
  input wire logic [3:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [15:0] host_rdata,
  // Device register bus
  output logic [7:0] dev_addr,
  output logic [15:0] dev_wdata,
  output logic dev_wr,
  output logic dev_rd,
  input wire logic [15:0] dev_rdata
);

  typedef enum {
    ST_IDLE, ST_SEL, ST_ALO, ST_AHI, ST_D0L, ST_D0H, ST_D1L, ST_D1H,
    ST_MLO, ST_MHI, ST_START, ST_PAUSE, ST_CANCEL, ST_POLL, ST_ERR,
    ST_RMLO, ST_RMHI
  } step_e;

  function automatic logic [15:0] sel_of(input logic [3:0] op);
    logic [15:0] s;
    s = flash_seq_pkg::ZERO_WORD;
    case (op)
      flash_seq_pkg::OP_WORD: s = flash_seq_pkg::WORD_PROG_SEL;
      flash_seq_pkg::OP_DWORD: s = flash_seq_pkg::DWORD_PROG_SEL;
      flash_seq_pkg::OP_ERASE: s = flash_seq_pkg::ERASE_SEL;
      default: s = flash_seq_pkg::SET_PROTECT_SEL;
    endcase
    return s;
  endfunction

  function automatic logic is_guard_op(input logic [3:0] op);
    return op == flash_seq_pkg::OP_GUARD_OFF ||
      op == flash_seq_pkg::OP_GUARD_BACK;
  endfunction

  step_e st_r, nx;
  logic pend_r, arm_r, armed_r, suspended_r, resuming_r, guarded_r;
  logic done_r, refused_r;
  logic [3:0] op_r, saved_op_r;
  logic [4:0] slots_r;
  logic [15:0] sel_r, err_r, rmask_lo_r, rmask_hi_r;
  logic [15:0] addr_lo_r, addr_hi_r, d0l_r, d0h_r, d1l_r, d1h_r;
  logic [15:0] mask_lo_r, mask_hi_r;
  logic req_valid, port_done, cmd_wr, accept, clr_wr, busy;
  logic [15:0] port_rdata;
  logic [3:0] cmd_op;
  logic after_fin;
  flash_seq_pkg::bus_req_s req;
  step_e after_load;

  assign busy = st_r != ST_IDLE;
  assign cmd_op = host_wdata[3:0];
  assign cmd_wr = host_wr && host_addr == flash_seq_pkg::H_CMD;
  assign clr_wr = host_wr && host_addr == flash_seq_pkg::H_STATUS;
  assign req_valid = busy && !pend_r;
  assign after_load = arm_r ? ST_IDLE : ST_START;
  assign after_fin = port_done && nx == ST_IDLE;

  // Which commands the current state allows
  always_comb
  begin
    accept = 1'b0;
    if (!busy)
    begin
      unique case (cmd_op)
        flash_seq_pkg::OP_WORD, flash_seq_pkg::OP_DWORD,
        flash_seq_pkg::OP_ERASE, flash_seq_pkg::OP_PROT,
        flash_seq_pkg::OP_GUARD_ON:
          accept = !armed_r && !suspended_r;
        flash_seq_pkg::OP_GUARD_OFF:
          accept = !armed_r && !suspended_r && guarded_r &&
            slots_r < flash_seq_pkg::GUARD_SLOTS;
        flash_seq_pkg::OP_GUARD_BACK:
          accept = !armed_r && !suspended_r &&
            slots_r < flash_seq_pkg::GUARD_SLOTS;
        flash_seq_pkg::OP_SUSPEND:
          accept = !armed_r && !suspended_r &&
            saved_op_r inside {flash_seq_pkg::OP_WORD,
            flash_seq_pkg::OP_DWORD, flash_seq_pkg::OP_ERASE};
        flash_seq_pkg::OP_RESUME:
          accept = suspended_r;
        flash_seq_pkg::OP_GO, flash_seq_pkg::OP_CANCEL:
          accept = armed_r;
        default:
          accept = 1'b0;
      endcase
    end
  end

  // Step order of each operation
  always_comb
  begin
    nx = ST_IDLE;
    unique case (st_r)
      ST_IDLE: nx = ST_IDLE;
      ST_SEL:
        if (resuming_r)
          nx = ST_START;
        else if (op_r == flash_seq_pkg::OP_ERASE)
          nx = ST_MLO;
        else
          nx = ST_ALO;
      ST_ALO: nx = ST_AHI;
      ST_AHI:
        nx = op_r == flash_seq_pkg::OP_GUARD_BACK ? ST_D0H : ST_D0L;
      ST_D0L:
        if (op_r inside {flash_seq_pkg::OP_GUARD_ON,
            flash_seq_pkg::OP_GUARD_OFF})
          nx = after_load;
        else
          nx = ST_D0H;
      ST_D0H:
        nx = op_r == flash_seq_pkg::OP_DWORD ? ST_D1L : after_load;
      ST_D1L: nx = ST_D1H;
      ST_D1H: nx = after_load;
      ST_MLO: nx = ST_MHI;
      ST_MHI: nx = after_load;
      ST_START: nx = ST_POLL;
      ST_PAUSE: nx = ST_POLL;
      ST_CANCEL: nx = ST_IDLE;
      ST_POLL:
        if (port_rdata[flash_seq_pkg::LOCK_BIT])
          nx = ST_POLL;
        else if (op_r == flash_seq_pkg::OP_SUSPEND)
          nx = ST_IDLE;
        else
          nx = ST_ERR;
      ST_ERR:
        nx = op_r == flash_seq_pkg::OP_ERASE ? ST_RMLO : ST_IDLE;
      ST_RMLO: nx = ST_RMHI;
      ST_RMHI:
        nx = resuming_r && (port_rdata | rmask_lo_r) != 16'h0000 ?
          ST_SEL : ST_IDLE;
    endcase
  end

  // One device access per step
  always_comb
  begin
    req = '0;
    req.wr = 1'b1;
    unique case (st_r)
      ST_IDLE: req.wr = 1'b0;
      ST_SEL:
      begin
        req.addr = flash_seq_pkg::REG_OP_CONTROL_HIGH;
        req.wdata = sel_r;
      end
      ST_ALO:
      begin
        req.addr = flash_seq_pkg::REG_TARGET_ADDR_LOW;
        req.wdata = addr_lo_r;
        if (op_r == flash_seq_pkg::OP_DWORD)
          req.wdata[flash_seq_pkg::ADDR_BIT2] = 1'b0;
        if (op_r == flash_seq_pkg::OP_GUARD_ON)
          req.wdata = flash_seq_pkg::NV_ACCESS_GUARD_REG0_LOW;
        if (is_guard_op(op_r))
          req.wdata = flash_seq_pkg::NV_GUARD_DISABLE_REG_LOW;
      end
      ST_AHI:
      begin
        req.addr = flash_seq_pkg::REG_TARGET_ADDR_HIGH;
        req.wdata = op_r >= flash_seq_pkg::OP_GUARD_ON ?
          flash_seq_pkg::NV_GUARD_ADDR_HIGH : addr_hi_r;
      end
      ST_D0L:
      begin
        req.addr = flash_seq_pkg::REG_DATA0_LOW;
        req.wdata = d0l_r;
        if (op_r == flash_seq_pkg::OP_GUARD_ON)
          req.wdata = flash_seq_pkg::GUARD_ON_DATA;
        if (op_r == flash_seq_pkg::OP_GUARD_OFF)
          req.wdata = flash_seq_pkg::CLEAR_BIT0_DATA;
      end
      ST_D0H:
      begin
        req.addr = flash_seq_pkg::REG_DATA0_HIGH;
        req.wdata = op_r == flash_seq_pkg::OP_GUARD_BACK ?
          flash_seq_pkg::CLEAR_BIT0_DATA : d0h_r;
      end
      ST_D1L:
      begin
        req.addr = flash_seq_pkg::REG_DATA1_LOW;
        req.wdata = d1l_r;
      end
      ST_D1H:
      begin
        req.addr = flash_seq_pkg::REG_DATA1_HIGH;
        req.wdata = d1h_r;
      end
      ST_MLO:
      begin
        req.addr = flash_seq_pkg::REG_SECTOR_MASK_LOW;
        req.wdata = mask_lo_r;
      end
      ST_MHI:
      begin
        req.addr = flash_seq_pkg::REG_SECTOR_MASK_HIGH;
        req.wdata = mask_hi_r;
      end
      ST_START:
      begin
        req.addr = flash_seq_pkg::REG_OP_CONTROL_HIGH;
        req.wdata = sel_r | flash_seq_pkg::OP_START_BIT;
      end
      ST_PAUSE:
      begin
        req.addr = flash_seq_pkg::REG_OP_CONTROL_HIGH;
        req.wdata = sel_r | flash_seq_pkg::PAUSE_REQUEST;
      end
      ST_CANCEL:
      begin
        req.addr = flash_seq_pkg::REG_OP_CONTROL_HIGH;
        req.wdata = flash_seq_pkg::ZERO_WORD;
      end
      ST_POLL:
      begin
        req = '0;
        req.rd = 1'b1;
        req.addr = flash_seq_pkg::REG_OP_CONTROL_LOW;
      end
      ST_ERR:
      begin
        req = '0;
        req.rd = 1'b1;
        req.addr = flash_seq_pkg::REG_OP_ERROR;
      end
      ST_RMLO:
      begin
        req = '0;
        req.rd = 1'b1;
        req.addr = flash_seq_pkg::REG_SECTOR_MASK_LOW;
      end
      ST_RMHI:
      begin
        req = '0;
        req.rd = 1'b1;
        req.addr = flash_seq_pkg::REG_SECTOR_MASK_HIGH;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_r <= ST_IDLE;
      pend_r <= 1'b0;
      op_r <= flash_seq_pkg::OP_NONE;
      saved_op_r <= flash_seq_pkg::OP_NONE;
      sel_r <= 16'h0000;
      arm_r <= 1'b0;
      resuming_r <= 1'b0;
    end
    else if (accept && cmd_wr)
    begin
      arm_r <= host_wdata[flash_seq_pkg::CMD_ARM_BIT];
      op_r <= cmd_op;
      unique case (cmd_op)
        flash_seq_pkg::OP_SUSPEND: st_r <= ST_PAUSE;
        flash_seq_pkg::OP_CANCEL: st_r <= ST_CANCEL;
        flash_seq_pkg::OP_GO:
        begin
          op_r <= saved_op_r;
          st_r <= ST_START;
        end
        flash_seq_pkg::OP_RESUME:
        begin
          // Erase may have ended while paused, so check its mask first
          op_r <= saved_op_r;
          resuming_r <= 1'b1;
          st_r <= saved_op_r == flash_seq_pkg::OP_ERASE ? ST_RMLO : ST_SEL;
        end
        default:
        begin
          saved_op_r <= cmd_op;
          sel_r <= sel_of(cmd_op);
          st_r <= ST_SEL;
        end
      endcase
    end
    else
    begin
      if (req_valid)
        pend_r <= 1'b1;
      if (port_done)
      begin
        pend_r <= 1'b0;
        st_r <= nx;
        if (st_r == ST_START)
          resuming_r <= 1'b0;
        if (st_r == ST_RMHI && nx == ST_IDLE)
          resuming_r <= 1'b0;
      end
    end
  end

  // Operation flags and status
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      armed_r <= 1'b0;
      suspended_r <= 1'b0;
      guarded_r <= 1'b0;
      slots_r <= 5'h00;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      err_r <= 16'h0000;
      rmask_lo_r <= 16'h0000;
      rmask_hi_r <= 16'h0000;
    end
    else
    begin
      // Sticky bits: a new event wins over a clear in the same cycle
      if (clr_wr && host_wdata[flash_seq_pkg::ST_DONE])
        done_r <= 1'b0;
      if (clr_wr && host_wdata[flash_seq_pkg::ST_REFUSED])
        refused_r <= 1'b0;
      if (cmd_wr && !accept)
        refused_r <= 1'b1;
      if (after_fin)
        done_r <= 1'b1;
      if (port_done)
      begin
        unique case (st_r)
          ST_START:
          begin
            armed_r <= 1'b0;
            suspended_r <= 1'b0;
            if (is_guard_op(op_r))
              slots_r <= slots_r + 5'h01;
          end
          ST_CANCEL: armed_r <= 1'b0;
          ST_POLL:
            if (nx == ST_IDLE)
              suspended_r <= 1'b1;
          ST_ERR:
          begin
            err_r <= port_rdata;
            if (op_r == flash_seq_pkg::OP_GUARD_ON &&
                port_rdata == 16'h0000)
              guarded_r <= 1'b1;
          end
          ST_RMLO: rmask_lo_r <= port_rdata;
          ST_RMHI:
          begin
            rmask_hi_r <= port_rdata;
            if (resuming_r && nx == ST_IDLE)
              suspended_r <= 1'b0;
          end
          default:
            if (arm_r && nx == ST_IDLE)
              armed_r <= 1'b1;
        endcase
      end
    end
  end

  // Host setup registers, frozen while a sequence runs
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      addr_lo_r <= 16'h0000;
      addr_hi_r <= 16'h0000;
      d0l_r <= 16'hffff;
      d0h_r <= 16'hffff;
      d1l_r <= 16'hffff;
      d1h_r <= 16'hffff;
      mask_lo_r <= 16'h0000;
      mask_hi_r <= 16'h0000;
    end
    else if (host_wr && !busy)
    begin
      unique case (host_addr)
        flash_seq_pkg::H_ADDR_LO: addr_lo_r <= host_wdata;
        flash_seq_pkg::H_ADDR_HI: addr_hi_r <= host_wdata;
        flash_seq_pkg::H_D0L: d0l_r <= host_wdata;
        flash_seq_pkg::H_D0H: d0h_r <= host_wdata;
        flash_seq_pkg::H_D1L: d1l_r <= host_wdata;
        flash_seq_pkg::H_D1H: d1h_r <= host_wdata;
        flash_seq_pkg::H_MASK_LO: mask_lo_r <= host_wdata;
        flash_seq_pkg::H_MASK_HI: mask_hi_r <= host_wdata;
        default: ;
      endcase
    end
  end

  // Host read data, one cycle after the strobe
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      host_rdata <= 16'h0000;
    else if (host_rd)
    begin
      host_rdata <= 16'h0000;
      unique case (host_addr)
        flash_seq_pkg::H_ADDR_LO: host_rdata <= addr_lo_r;
        flash_seq_pkg::H_ADDR_HI: host_rdata <= addr_hi_r;
        flash_seq_pkg::H_D0L: host_rdata <= d0l_r;
        flash_seq_pkg::H_D0H: host_rdata <= d0h_r;
        flash_seq_pkg::H_D1L: host_rdata <= d1l_r;
        flash_seq_pkg::H_D1H: host_rdata <= d1h_r;
        flash_seq_pkg::H_MASK_LO: host_rdata <= mask_lo_r;
        flash_seq_pkg::H_MASK_HI: host_rdata <= mask_hi_r;
        flash_seq_pkg::H_STATUS:
        begin
          host_rdata[flash_seq_pkg::ST_BUSY] <= busy;
          host_rdata[flash_seq_pkg::ST_DONE] <= done_r;
          host_rdata[flash_seq_pkg::ST_REFUSED] <= refused_r;
          host_rdata[flash_seq_pkg::ST_ARMED] <= armed_r;
          host_rdata[flash_seq_pkg::ST_SUSPENDED] <= suspended_r;
          host_rdata[flash_seq_pkg::ST_GUARDED] <= guarded_r;
          host_rdata[flash_seq_pkg::ST_ERROR] <= err_r != 16'h0000;
          host_rdata[flash_seq_pkg::ST_SLOTS_LSB +: 5] <= slots_r;
        end
        flash_seq_pkg::H_ERR: host_rdata <= err_r;
        flash_seq_pkg::H_RMASK_LO: host_rdata <= rmask_lo_r;
        flash_seq_pkg::H_RMASK_HI: host_rdata <= rmask_hi_r;
        default: host_rdata <= 16'h0000;
      endcase
    end
  end

  reg_bus_port u_port (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .req_valid(req_valid),
    .req(req),
    .done(port_done),
    .rdata(port_rdata),
    .dev_addr(dev_addr),
    .dev_wdata(dev_wdata),
    .dev_wr(dev_wr),
    .dev_rd(dev_rd),
    .dev_rdata(dev_rdata)
  );

endmodule
`default_nettype wire

/* File: flash_write_op_sequencer_chk.sv */
`default_nettype none
module flash_write_op_sequencer_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Host port
  input wire logic [3:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_rdata,
  // Device bus
  input wire logic [7:0] dev_addr,
  input wire logic [15:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  input wire logic [15:0] dev_rdata
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic ch_w;
  logic kick_w;
  logic poll_r;
  logic lock_r;
  logic pause_request_r;
  logic [15:0] sel_r;
  assign ch_w = dev_wr && dev_addr == flash_seq_pkg::REG_OP_CONTROL_HIGH;
  assign kick_w = ch_w && (dev_wdata[15] || dev_wdata[14]);
  // Lock follows the polled data, not a guessed delay
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      poll_r <= 1'b0;
      lock_r <= 1'b0;
      pause_request_r <= 1'b0;
      sel_r <= 16'h0000;
    end
    else
    begin
      poll_r <= dev_rd && dev_addr == flash_seq_pkg::REG_OP_CONTROL_LOW;
      if (kick_w)
        lock_r <= 1'b1;
      else if (poll_r && !dev_rdata[flash_seq_pkg::LOCK_BIT])
        lock_r <= 1'b0;
      if (kick_w)
        pause_request_r <= dev_wdata[14];
      if (ch_w && !kick_w)
        sel_r <= dev_wdata;
    end
  end
  chk_bus_excl: assert property (!(dev_wr && dev_rd))
  else $error("device read and write strobes together");
  chk_wr_space: assert property (dev_wr |=> !(dev_wr || dev_rd) [*2])
  else $error("device access too soon after a write");
  chk_rd_space: assert property (dev_rd |=> !(dev_wr || dev_rd) [*3])
  else $error("device access too soon after a read");
  chk_kick_poll: assert property (kick_w |-> ##[3:6]
    (dev_rd && dev_addr == flash_seq_pkg::REG_OP_CONTROL_LOW))
  else $error("no lock poll after start or pause");
  chk_no_wr_locked: assert property (dev_wr |-> !lock_r)
  else $error("device write while lock was set");
  chk_err_after: assert property (poll_r && !dev_rdata[4] && !pause_request_r
    |-> ##[1:6] (dev_rd && dev_addr == flash_seq_pkg::REG_OP_ERROR))
  else $error("error register not read after operation");
  chk_dword_bit2: assert property (dev_wr && sel_r[12] &&
    dev_addr == flash_seq_pkg::REG_TARGET_ADDR_LOW |-> !dev_wdata[2])
  else $error("double word address bit two not cleared");
  chk_cancel_quiet: assert property (ch_w && dev_wdata == 16'h0000
    |=> !(ch_w && dev_wdata[15]) [*8])
  else $error("start issued after cancel");
  chk_start_sel: assert property (ch_w && dev_wdata[15]
    |-> dev_wdata[13:8] == sel_r[13:8])
  else $error("start select differs from selection");
endmodule
bind flash_write_op_sequencer flash_write_op_sequencer_chk chk_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
  .host_rdata(host_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
  .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata));
`default_nettype wire

/* File: flash_dev_model.sv */
`default_nettype none
module flash_dev_model #(
  parameter int BUSY = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register bus from the sequencer
  input wire logic [7:0] dev_addr,
  input wire logic [15:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic dev_rd,
  output logic [15:0] dev_rdata
);
  logic [15:0] r [0:10];
  logic [15:0] sel_r;
  logic [15:0] g0_r;
  logic [15:0] wp_r;
  logic [31:0] prog_addr;
  logic [4:0] slots;
  logic [7:0] cnt_r;
  logic pause_request_r;
  logic res_r;
  int n_start;
  logic [3:0] ix;
  assign ix = dev_addr[3:0];
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 11; i++)
        r[i] <= 16'h0000;
      {sel_r, prog_addr, slots, cnt_r, pause_request_r, res_r} <= '0;
      g0_r <= 16'hffff;
      wp_r <= 16'hffff;
      n_start <= 0;
    end
    else
    begin
      if (dev_wr && !r[0][4] && dev_addr <= 8'h0a)
      begin
        r[ix] <= dev_wdata;
        if (ix == 4'h1 && (dev_wdata[15] || dev_wdata[14]))
        begin
          r[0][4] <= 1'b1;
          cnt_r <= 8'(BUSY);
          res_r <= pause_request_r && dev_wdata[15];
          if (dev_wdata[15])
            n_start <= n_start + 1;
          if (dev_wdata[15])
            r[10] <= {15'h0, pause_request_r && dev_wdata[13:8] != sel_r[13:8]};
          if (!pause_request_r && dev_wdata[15])
            sel_r <= dev_wdata;
          // A finished erase leaves nothing to suspend
          if (dev_wdata[14] && !sel_r[11])
            pause_request_r <= 1'b1;
        end
      end
      if (cnt_r != 8'h00)
        cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01)
      begin
        r[0][4] <= 1'b0;
        r[1][15:14] <= 2'b00;
        if (res_r)
          pause_request_r <= 1'b0;
        else if (r[1][15])
        begin
          if (r[1][13])
            prog_addr <= {r[5], r[4]};
          if (r[1][12])
            prog_addr <= {r[5], r[4] & 16'hfffb};
          if (r[1][11])
            {r[2], r[3]} <= 32'h0;
          if (r[1][8] && r[4] == flash_seq_pkg::NV_ACCESS_GUARD_REG0_LOW)
            g0_r <= r[6];
          else if (r[1][8] && r[4] == flash_seq_pkg::NV_GUARD_DISABLE_REG_LOW)
          begin
            if (slots == 5'h10 || (r[6] == 16'hfffe && g0_r != 16'hfffc))
              r[10] <= 16'h0002;
            else
              slots <= slots + 5'h01;
          end
          else if (r[1][8])
            wp_r <= r[6];
        end
      end
    end
  end
  // Between answers the line toggles so stale data never looks valid
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      dev_rdata <= 16'h0000;
    else if (dev_rd)
      dev_rdata <= (dev_addr <= 8'h0a) ? r[ix] : 16'h0000;
    else
      dev_rdata <= ~dev_rdata;
  end
endmodule
`default_nettype wire

/* File: flash_write_op_sequencer_bench.sv */
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got %h want %h", $time, (g), (e)); end end
module flash_write_op_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] host_addr = 4'h0;
  logic [15:0] host_wdata = 16'h0000;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [15:0] host_rdata;
  logic [7:0] dev_addr;
  logic [15:0] dev_wdata;
  logic dev_wr;
  logic dev_rd;
  logic [15:0] dev_rdata;
  logic [15:0] s;
  int n_fail = 0;
  int tests_run = 0;
  int n0;
  flash_write_op_sequencer dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata));
  flash_dev_model #(.BUSY(6)) dev (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
    .dev_rd(dev_rd), .dev_rdata(dev_rdata));
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic hw(input logic [3:0] a, input logic [15:0] d);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge sys_clk);
    host_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic hr(input logic [3:0] a, output logic [15:0] d);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge sys_clk);
    host_rd <= 1'b0;
    @(negedge sys_clk);
    d = host_rdata;
    @(posedge sys_clk);
  endtask
  task automatic op(input logic [15:0] c);
    hw(flash_seq_pkg::H_CMD, c);
    @(posedge sys_clk);
    for (int i = 0; i < 3000; i++)
    begin
      hr(flash_seq_pkg::H_STATUS, s);
      if (s[0] === 1'b0)
        break;
    end
    `CHK(s[0], 1'b0)
  endtask
  task automatic sb(input int b, input logic v);
    hr(flash_seq_pkg::H_STATUS, s);
    `CHK(s[b], v)
  endtask
  task automatic ld(input logic [15:0] a0, a1, d0, d1);
    hw(flash_seq_pkg::H_ADDR_LO, a0);
    hw(flash_seq_pkg::H_ADDR_HI, a1);
    hw(flash_seq_pkg::H_D0L, d0);
    hw(flash_seq_pkg::H_D0H, d1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #(60000 * 50);
    n_fail++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    hr(flash_seq_pkg::H_STATUS, s);
    `CHK(s, 16'h0000)
    hr(flash_seq_pkg::H_D1H, s);
    `CHK(s, 16'hffff)
    hr(4'hd, s);
    `CHK(s, 16'h0000)
    ld(16'h5554, 16'h0002, 16'haaaa, 16'haaaa);
    hw(flash_seq_pkg::H_CMD, {12'h0, flash_seq_pkg::OP_WORD});
    hw(flash_seq_pkg::H_ADDR_LO, 16'h1234);
    op({12'h0, flash_seq_pkg::OP_WORD});
    `CHK(dev.prog_addr, 32'h00025554)
    sb(flash_seq_pkg::ST_REFUSED, 1'b1);
    sb(flash_seq_pkg::ST_ERROR, 1'b0);
    hw(flash_seq_pkg::H_STATUS, 16'h0006);
    sb(flash_seq_pkg::ST_REFUSED, 1'b0);
    op({12'h0, flash_seq_pkg::OP_SUSPEND});
    sb(flash_seq_pkg::ST_SUSPENDED, 1'b1);
    op({12'h0, flash_seq_pkg::OP_RESUME});
    sb(flash_seq_pkg::ST_SUSPENDED, 1'b0);
    `CHK(dev.r[10], 16'h0000)
    ld(16'h555c, 16'h0003, 16'h55aa, 16'h55aa);
    hw(flash_seq_pkg::H_D1L, 16'haa55);
    hw(flash_seq_pkg::H_D1H, 16'haa55);
    op({12'h0, flash_seq_pkg::OP_DWORD});
    `CHK(dev.r[4], 16'h5558)
    `CHK(dev.r[9], 16'haa55)
    hw(flash_seq_pkg::H_MASK_LO, 16'h0003);
    hw(flash_seq_pkg::H_MASK_HI, 16'h0000);
    op({12'h0, flash_seq_pkg::OP_ERASE});
    hr(flash_seq_pkg::H_RMASK_LO, s);
    `CHK(s, 16'h0000)
    n0 = dev.n_start;
    op({12'h0, flash_seq_pkg::OP_SUSPEND});
    op({12'h0, flash_seq_pkg::OP_RESUME});
    `CHK(dev.n_start, n0)
    ld(16'hdfb4, 16'h000e, 16'hfff0, 16'hffff);
    op({12'h0, flash_seq_pkg::OP_PROT});
    `CHK(dev.wp_r, 16'hfff0)
    op({12'h0, flash_seq_pkg::OP_GUARD_OFF});
    sb(flash_seq_pkg::ST_REFUSED, 1'b1);
    `CHK(dev.slots, 5'h00)
    hw(flash_seq_pkg::H_STATUS, 16'h0006);
    op({12'h0, flash_seq_pkg::OP_GUARD_ON});
    `CHK(dev.g0_r, 16'hfffc)
    sb(flash_seq_pkg::ST_GUARDED, 1'b1);
    for (int i = 0; i < 16; i++)
      op({12'h0, i[0] ? flash_seq_pkg::OP_GUARD_BACK
                      : flash_seq_pkg::OP_GUARD_OFF});
    `CHK(dev.slots, flash_seq_pkg::GUARD_SLOTS)
    hr(flash_seq_pkg::H_STATUS, s);
    `CHK(s[12:8], 5'h10)
    op({12'h0, flash_seq_pkg::OP_GUARD_BACK});
    sb(flash_seq_pkg::ST_REFUSED, 1'b1);
    `CHK(dev.slots, 5'h10)
    n0 = dev.n_start;
    op({12'h1, flash_seq_pkg::OP_WORD});
    sb(flash_seq_pkg::ST_ARMED, 1'b1);
    op({12'h0, flash_seq_pkg::OP_CANCEL});
    sb(flash_seq_pkg::ST_ARMED, 1'b0);
    `CHK(dev.n_start, n0)
    op({12'h1, flash_seq_pkg::OP_WORD});
    op({12'h0, flash_seq_pkg::OP_GO});
    `CHK(dev.n_start, n0 + 1)
    conclude();
  end
endmodule
`undef CHK
`default_nettype wire
